//--- bench/test_usb_parallel_fifo_port.sv
/* Self-checking bench: APB host side plus external pin logic model.
 * Assumes ufp_port with a short wake count. */
`timescale 1ns/100ps
`include "ufp_regs.svh"
module test_usb_parallel_fifo_port;
    import ufp_pkg::*;
    localparam int WAKE = 20; // Short wake hold for simulation
    logic core_clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic fifo_data_oe, read_strobe_n, write_strobe, transmit_room_n, transmit_room_oe;
    logic receive_avail_in, receive_avail_n, receive_avail_oe;
    logic configured_awake_n, usb_resume_req, e;
    ufp_addr_t paddr;
    logic [31:0] pwdata, prdata, r;
    ufp_byte_t fifo_data_in, fifo_data_out, b;
    int n_fail = 0, num_checks = 0, n_wake = 0;
    ufp_port #(.WAKE_CYCLES(WAKE)) uut (.core_clk, .resetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .fifo_data_in, .fifo_data_out,
        .fifo_data_oe, .read_strobe_n, .write_strobe, .transmit_room_n, .transmit_room_oe,
        .receive_avail_in, .receive_avail_n, .receive_avail_oe, .configured_awake_n,
        .usb_resume_req);
    ufp_ext_logic ext (.core_clk, .fifo_data_out, .fifo_data_oe, .transmit_room_n,
        .receive_avail_n, .receive_avail_oe, .fifo_data_in, .read_strobe_n,
        .write_strobe, .receive_avail_in);
    always #20 core_clk = ~core_clk;
    // Count resume pulses
    always @(posedge core_clk) if (usb_resume_req === 1'b1) n_wake++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input ufp_addr_t a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rreg(input ufp_addr_t a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x);
    endtask
    task automatic stop_test;
        $display("Checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        $display("[FAIL] %0t watchdog timeout", $time);
        stop_test();
    end
    initial begin
        {core_clk, resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (2) @(posedge core_clk);
        chk({transmit_room_oe, receive_avail_oe}, 32'h0);
        resetn <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk({transmit_room_n, receive_avail_n}, 32'h1);
        // Two bytes toward the far logic, then one read too many
        apb(1'b1, `UFP_OFF_RXDATA, 32'h5a);
        apb(1'b1, `UFP_OFF_RXDATA, 32'hc3);
        repeat (4) @(posedge core_clk);
        chk(receive_avail_n, 32'h0);
        ext.rd(b);
        chk(b, 32'h5a);
        chk(fifo_data_oe, 32'h0);
        ext.rd(b);
        chk(b, 32'hc3);
        chk(receive_avail_n, 32'h1);
        // Read on empty re-drives the last byte
        ext.rd(b);
        chk(b, 32'hc3);
        // Two bytes from the far logic
        ext.wr(8'ha5);
        ext.wr(8'h3c);
        rreg(`UFP_OFF_LEVEL, 32'h0002_0000);
        rreg(`UFP_OFF_TXDATA, 32'h1a5);
        rreg(`UFP_OFF_TXDATA, 32'h13c);
        chk(transmit_room_n, 32'h0);
        apb(1'b0, 12'h018, 32'h0);
        chk({r[30:0], e}, 32'h1);
        // Power enable for every configured/suspended pair
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `UFP_OFF_CTRL, 32'(i));
            repeat (2) @(posedge core_clk);
            chk({configured_awake_n, receive_avail_oe}, {30'h0, i != 1, 1'b1});
        end
        apb(1'b1, `UFP_OFF_CTRL, 32'h6);
        repeat (2) @(posedge core_clk);
        chk(receive_avail_oe, 32'h0);
        ext.wake(WAKE - 8);
        chk(n_wake, 32'h0);
        ext.wake(WAKE + 10);
        chk(n_wake, 32'h1);
        rreg(`UFP_OFF_WAKE, 32'h1);
        apb(1'b1, `UFP_OFF_WAKE, 32'h1);
        rreg(`UFP_OFF_WAKE, 32'h0);
        apb(1'b1, `UFP_OFF_CTRL, 32'h1);
        // Reset in mid-run
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk({transmit_room_oe, receive_avail_oe, configured_awake_n}, 32'h1);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        rreg(`UFP_OFF_CTRL, 32'h0);
        rreg(`UFP_OFF_STATUS, 32'h5);
        stop_test();
    end
endmodule

//--- bench/ufp_ext_logic.sv
/* External logic model: reads and writes bytes over the strobed pins
 * and pulls the status pin low to wake. Assumes 25 MHz core_clk. */
`timescale 1ns/100ps
module ufp_ext_logic (
    input  wire logic               core_clk,
    input  wire ufp_pkg::ufp_byte_t fifo_data_out,
    input  wire logic               fifo_data_oe,
    input  wire logic               transmit_room_n,
    input  wire logic               receive_avail_n,
    input  wire logic               receive_avail_oe,
    output ufp_pkg::ufp_byte_t      fifo_data_in,
    output logic                    read_strobe_n,
    output logic                    write_strobe,
    output logic                    receive_avail_in
);
    import ufp_pkg::*;
    ufp_byte_t drv_val;  // Byte we put on the bus
    logic      drv_oe;   // We drive the bus
    logic      wake_low; // Holding the wake pin low
    ufp_byte_t last = 8'h00; // Last bus level
    // A floating bus toggles so stale bytes never match
    always @(posedge core_clk) last <= fifo_data_in;
    assign fifo_data_in = fifo_data_oe ? fifo_data_out : (drv_oe ? drv_val : ~last);
    // Pin is pulled up when nobody drives it
    assign receive_avail_in = receive_avail_oe ? receive_avail_n : !wake_low;
    initial begin
        read_strobe_n = 1'b1;
        write_strobe = 1'b0;
        drv_oe = 1'b0;
        drv_val = 8'h00;
        wake_low = 1'b0;
    end
    // One low pulse of the read strobe, byte taken while it is low
    task automatic rd(output ufp_byte_t b);
        @(posedge core_clk);
        read_strobe_n <= 1'b0;
        // Ends when fifo_data_oe rises; otherwise only the bench watchdog ends it
        while (fifo_data_oe !== 1'b1) begin
            @(posedge core_clk);
        end
        repeat (2) @(posedge core_clk);
        b = fifo_data_in;
        read_strobe_n <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask
    // One write pulse; data held 4 cycles before and 3 after the fall
    task automatic wr(input ufp_byte_t b);
        while (transmit_room_n !== 1'b0) begin
            @(posedge core_clk);
        end
        @(posedge core_clk);
        drv_oe <= 1'b1;
        drv_val <= b;
        write_strobe <= 1'b1;
        repeat (4) @(posedge core_clk);
        write_strobe <= 1'b0;
        repeat (3) @(posedge core_clk);
        drv_oe <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    // Hold the wake pin low for n cycles
    task automatic wake(input int n);
        @(posedge core_clk);
        wake_low <= 1'b1;
        repeat (n) @(posedge core_clk);
        wake_low <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
endmodule

//--- hdl/ufp_fifo.sv
/*
 * Synchronous first-word-fall-through FIFO with valid/ready on both sides.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/100ps
module ufp_fifo #(
    parameter int  WIDTH = 8,
    parameter int  DEPTH = 16,
    localparam int AW    = $clog2(DEPTH),
    localparam int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic             core_clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic             push_valid,
    output logic                  push_ready,
    output logic      [WIDTH-1:0] pop_data,
    output logic                  pop_valid,
    input  wire logic             pop_ready,
    output logic      [CW-1:0]    level
);
    logic [WIDTH-1:0] mem [DEPTH];  // Storage array
    logic [AW-1:0]    wptr;         // Next slot to fill
    logic [AW-1:0]    rptr;         // Oldest entry
    logic             do_push;      // Accepted push
    logic             do_pop;       // Accepted pop

    // Pointers wrap by overflow, so the depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("ufp_fifo: DEPTH must be a power of two, at least 2");
    end

    // Handshakes and show-ahead head
    assign push_ready = (level != CW'(DEPTH));
    assign pop_valid  = (level != '0);
    assign pop_data   = mem[rptr];
    assign do_push    = push_valid & push_ready;
    assign do_pop     = pop_valid & pop_ready;

    // Storage write, no reset needed on data
    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wptr] <= push_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wptr  <= '0;
            rptr  <= '0;
            level <= '0;
        end else begin
            if (do_push) begin
                wptr <= wptr + AW'(1);
            end
            if (do_pop) begin
                rptr <= rptr + AW'(1);
            end
            // Push and pop together leave the level alone
            if (do_push && !do_pop) begin
                level <= level + CW'(1);
            end else if (do_pop && !do_push) begin
                level <= level - CW'(1);
            end
        end
    end
endmodule

//--- hdl/ufp_pkg.sv
/*
 * Types shared by the parallel FIFO port modules.
 * Assumes nothing beyond a SystemVerilog tool.
 */
package ufp_pkg;
    // Strobe phase, one-hot
    typedef enum logic [1:0] {
        UFP_IDLE = 2'b01,
        UFP_BUSY = 2'b10
    } ufp_phase_e;
    // One byte on the data port
    typedef logic [7:0]  ufp_byte_t;
    // APB byte address
    typedef logic [11:0] ufp_addr_t;
endpackage

//--- hdl/ufp_port.sv
/*
 * Parallel FIFO port: byte-wide strobed pin interface to external logic,
 * receive and transmit FIFOs, status flags, power-enable and remote
 * wakeup, with an APB slave for the USB engine side.
 * Assumes pins arrive asynchronously and the APB master runs on core_clk.
 */
// The implementer's own choices: the register addresses and the APB register port.
// Behaviour
// - Read strobe low presents current receive byte.
// - Read strobe falling fetches next receive byte.
// - Write strobe falling captures data into transmit.
// - No writes while transmit room flag high.
// - Receive flag low only when bytes wait.
// - Status outputs float while in reset.
// - Power-enable low when configured, high when suspended.
// - Wake enabled and suspended turns receive pin input.
// - Wake pin low 20ms requests USB resume.
// - Reset input low returns device to reset.
`timescale 1ns/100ps
`include "ufp_regs.svh"
module ufp_port #(
    parameter int RX_DEPTH    = 16,
    parameter int TX_DEPTH    = 16,
    parameter int WAKE_CYCLES = `UFP_WAKE_CYCLES
) (
    input  wire logic              core_clk,
    input  wire logic              resetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire ufp_pkg::ufp_addr_t paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Pin side
    input  wire ufp_pkg::ufp_byte_t fifo_data_in,
    output ufp_pkg::ufp_byte_t     fifo_data_out,
    output logic                   fifo_data_oe,
    input  wire logic              read_strobe_n,
    input  wire logic              write_strobe,
    output logic                   transmit_room_n,
    output logic                   transmit_room_oe,
    input  wire logic              receive_avail_in,
    output logic                   receive_avail_n,
    output logic                   receive_avail_oe,
    output logic                   configured_awake_n,
    // To the USB engine
    output logic                   usb_resume_req
);
    import ufp_pkg::*;

    localparam int RCW = $clog2(RX_DEPTH + 1);     // Receive level width
    localparam int TCW = $clog2(TX_DEPTH + 1);     // Transmit level width
    localparam int WCW = $clog2(WAKE_CYCLES + 1);  // Wake counter width

    // Refuse settings the logic cannot serve
    if (RX_DEPTH < 2 || TX_DEPTH < 2 || RX_DEPTH > 65535 || TX_DEPTH > 65535)
    begin : g_bad_depth
        $error("ufp_port: FIFO depths must lie in 2..65535");
    end
    if (WAKE_CYCLES < 1) begin : g_bad_wake
        $error("ufp_port: WAKE_CYCLES must be at least 1");
    end

    logic [2:0]       rd_sync;       // Read strobe synchroniser
    logic [2:0]       wr_sync;       // Write strobe synchroniser
    logic [2:0]       wk_sync;       // Wake pin synchroniser
    logic [7:0]       d_s1;          // Data pin stage one
    logic [7:0]       d_s2;          // Data pin stage two
    logic [7:0]       d_s3;          // Data pin stage three
    logic             rd_lvl;        // Filtered read strobe level
    logic             wr_lvl;        // Filtered write strobe level
    logic             wk_lvl;        // Filtered wake pin level
    logic             rd_fall;       // Read strobe high to low
    logic             rd_rise;       // Read strobe low to high
    logic             wr_fall;       // Write strobe high to low
    logic             wr_rise;       // Write strobe low to high
    ufp_phase_e       rd_state;      // Read strobe phase
    ufp_phase_e       next_rd_state;
    ufp_phase_e       wr_state;      // Write strobe phase
    ufp_phase_e       next_wr_state;
    logic [2:0]       ctrl;          // Configured, suspended, wake enable
    logic             wake_seen;     // Sticky resume flag
    logic             wake_mode;     // Receive pin acts as input
    logic [WCW-1:0]   wake_cnt;      // Cycles the wake pin has been low
    logic             wake_armed;    // One request per low period
    logic             wake_fire;     // Resume request this cycle
    logic             apb_setup;     // First cycle of a transfer
    logic             apb_done;      // Completing edge of a transfer
    logic             hit;           // Address is mapped
    logic [31:0]      rd_mux;        // Read data selected by address
    logic [7:0]       rx_head;       // Oldest receive byte
    logic             rx_valid;      // Receive FIFO not empty
    logic             rx_ready;      // Receive FIFO has room
    logic             rx_push;       // Engine writes a receive byte
    logic [RCW-1:0]   rx_level;      // Receive fill level
    logic [7:0]       tx_head;       // Oldest transmit byte
    logic             tx_valid;      // Transmit FIFO not empty
    logic             tx_ready;      // Transmit FIFO has room
    logic             tx_pop;        // Engine reads a transmit byte
    logic [TCW-1:0]   tx_level;      // Transmit fill level

    // Three-stage pin synchronisers; only stages two and three are compared
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_sync <= `UFP_SYNC_HIGH;
            wr_sync <= `UFP_SYNC_LOW;
            wk_sync <= `UFP_SYNC_HIGH;
            d_s1    <= '0;
            d_s2    <= '0;
            d_s3    <= '0;
        end else begin
            rd_sync <= {rd_sync[1:0], read_strobe_n};
            wr_sync <= {wr_sync[1:0], write_strobe};
            wk_sync <= {wk_sync[1:0], receive_avail_in};
            d_s1    <= fifo_data_in;
            d_s2    <= d_s1;
            d_s3    <= d_s2;
        end
    end

    // Edges count once the second and third stages agree
    assign rd_fall = rd_lvl && (rd_sync[2] == rd_sync[1]) && !rd_sync[2];
    assign rd_rise = !rd_lvl && (rd_sync[2] == rd_sync[1]) && rd_sync[2];
    assign wr_fall = wr_lvl && (wr_sync[2] == wr_sync[1]) && !wr_sync[2];
    assign wr_rise = !wr_lvl && (wr_sync[2] == wr_sync[1]) && wr_sync[2];

    // Filtered levels
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_lvl <= 1'b1;
            wr_lvl <= 1'b0;
            wk_lvl <= 1'b1;
        end else begin
            if (rd_sync[2] == rd_sync[1]) begin
                rd_lvl <= rd_sync[2];
            end
            if (wr_sync[2] == wr_sync[1]) begin
                wr_lvl <= wr_sync[2];
            end
            if (wk_sync[2] == wk_sync[1]) begin
                wk_lvl <= wk_sync[2];
            end
        end
    end

    // Strobe phase machines
    always_comb begin
        next_rd_state = rd_state;
        next_wr_state = wr_state;
        case (rd_state)
            UFP_IDLE: if (rd_fall) next_rd_state = UFP_BUSY;
            UFP_BUSY: if (rd_rise) next_rd_state = UFP_IDLE;
            default:  next_rd_state = UFP_IDLE;
        endcase
        case (wr_state)
            UFP_IDLE: if (wr_rise) next_wr_state = UFP_BUSY;
            UFP_BUSY: if (wr_fall) next_wr_state = UFP_IDLE;
            default:  next_wr_state = UFP_IDLE;
        endcase
    end

    // Phase registers; reset input returns both to idle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_state <= UFP_IDLE;
            wr_state <= UFP_IDLE;
        end else begin
            rd_state <= next_rd_state;
            wr_state <= next_wr_state;
        end
    end

    // Receive FIFO: engine fills it, read strobe drains it
    ufp_fifo #(
        .WIDTH (8),
        .DEPTH (RX_DEPTH)
    ) u_rx_fifo (
        .core_clk   (core_clk),
        .resetn     (resetn),
        .push_data  (pwdata[7:0]),
        .push_valid (rx_push),
        .push_ready (rx_ready),
        .pop_data   (rx_head),
        .pop_valid  (rx_valid),
        .pop_ready  (rd_fall),
        .level      (rx_level)
    );

    // Transmit FIFO: write strobe fills it, engine drains it
    ufp_fifo #(
        .WIDTH (8),
        .DEPTH (TX_DEPTH)
    ) u_tx_fifo (
        .core_clk   (core_clk),
        .resetn     (resetn),
        .push_data  (d_s3),
        .push_valid (wr_fall),
        .push_ready (tx_ready),
        .pop_data   (tx_head),
        .pop_valid  (tx_valid),
        .pop_ready  (tx_pop),
        .level      (tx_level)
    );

    // Data port: driven only while the read strobe is low
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fifo_data_out <= '0;
            fifo_data_oe  <= 1'b0;
        end else begin
            fifo_data_oe <= !rd_lvl || rd_fall;
            // Fetch the next byte on the falling edge; empty keeps the old one
            if (rd_fall && rx_valid) begin
                fifo_data_out <= rx_head;
            end
        end
    end

    // Status flags; enables stay low through reset so the pins float
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            transmit_room_n  <= 1'b1;
            transmit_room_oe <= 1'b0;
            receive_avail_n  <= 1'b1;
            receive_avail_oe <= 1'b0;
        end else begin
            transmit_room_oe <= 1'b1;
            receive_avail_oe <= !wake_mode;
            // High after each transfer, low again once a byte fits
            transmit_room_n <= wr_fall || (next_wr_state == UFP_BUSY) || !tx_ready;
            // High after each fetch until the strobe returns and bytes wait
            receive_avail_n <= (next_rd_state == UFP_BUSY) || !rx_valid;
        end
    end

    // Power enable follows configuration and suspend
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            configured_awake_n <= 1'b1;
        end else begin
            configured_awake_n <= !(ctrl[`UFP_CTRL_CONFIGURED]
                                    && !ctrl[`UFP_CTRL_SUSPENDED]);
        end
    end

    // Wake detect: time the low level on the receive pin while it is an input
    assign wake_mode = ctrl[`UFP_CTRL_SUSPENDED] && ctrl[`UFP_CTRL_WAKE_EN];
    assign wake_fire = wake_mode && !wk_lvl && wake_armed
                       && (wake_cnt == WCW'(WAKE_CYCLES - 1));

    // Counter saturates and wake_armed clears on the request, so one long low period gives one request
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wake_cnt       <= '0;
            wake_armed     <= 1'b1;
            usb_resume_req <= 1'b0;
        end else begin
            usb_resume_req <= wake_fire;
            if (!wake_mode || wk_lvl) begin
                wake_cnt   <= '0;
                wake_armed <= 1'b1;
            end else begin
                if (wake_cnt != WCW'(WAKE_CYCLES - 1)) begin
                    wake_cnt <= wake_cnt + WCW'(1);
                end
                if (wake_fire) begin
                    wake_armed <= 1'b0;
                end
            end
        end
    end

    // APB decode; no wait state, all answers registered in the setup cycle
    assign apb_setup = psel && !penable && !pready;
    assign apb_done  = psel && penable && pready;
    assign rx_push   = apb_done && pwrite && (paddr == `UFP_OFF_RXDATA);
    // Pop only a byte that was actually returned
    assign tx_pop    = apb_done && !pwrite && (paddr == `UFP_OFF_TXDATA)
                       && prdata[`UFP_TXD_VALID];

    // Read data and address hit
    always_comb begin
        rd_mux = '0;
        hit    = 1'b1;
        case (paddr)
            `UFP_OFF_CTRL:   rd_mux[2:0] = ctrl;
            `UFP_OFF_STATUS: begin
                rd_mux[`UFP_ST_RX_EMPTY] = !rx_valid;
                rd_mux[`UFP_ST_RX_FULL]  = !rx_ready;
                rd_mux[`UFP_ST_TX_EMPTY] = !tx_valid;
                rd_mux[`UFP_ST_TX_FULL]  = !tx_ready;
                rd_mux[`UFP_ST_RD_BUSY]  = (rd_state == UFP_BUSY);
                rd_mux[`UFP_ST_WR_BUSY]  = (wr_state == UFP_BUSY);
            end
            `UFP_OFF_RXDATA: rd_mux = '0;
            `UFP_OFF_TXDATA: rd_mux = {23'h0, tx_valid, tx_head};
            `UFP_OFF_WAKE:   rd_mux[`UFP_WAKE_SEEN] = wake_seen;
            `UFP_OFF_LEVEL: begin
                rd_mux[15:0]  = 16'(rx_level);
                rd_mux[31:16] = 16'(tx_level);
            end
            default:         hit = 1'b0;
        endcase
    end

    // APB answer registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup && !hit;
            // Read data is captured in setup and held through the access
            if (apb_setup) begin
                prdata <= pwrite ? 32'h0 : rd_mux;
            end
        end
    end

    // Control register and sticky wake flag; a new wake beats a clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl      <= `UFP_CTRL_RESET;
            wake_seen <= 1'b0;
        end else begin
            if (apb_done && pwrite && paddr == `UFP_OFF_CTRL) begin
                ctrl <= pwdata[2:0];
            end
            if (wake_fire) begin
                wake_seen <= 1'b1;
            end else if (apb_done && pwrite && paddr == `UFP_OFF_WAKE
                         && pwdata[`UFP_WAKE_SEEN]) begin
                wake_seen <= 1'b0;
            end
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    property p_drive_on_read;
        !rd_lvl |=> fifo_data_oe;
    endproperty
    a_drive_on_read: assert property (p_drive_on_read)
        else $error("data port not driven during read");

    property p_float_idle;
        rd_lvl && !rd_fall |=> !fifo_data_oe;
    endproperty
    a_float_idle: assert property (p_float_idle)
        else $error("data port driven outside read");

    property p_fetch;
        rd_fall && rx_valid && !rx_push |=> fifo_data_out == $past(rx_head)
                                && rx_level == $past(rx_level) - RCW'(1);
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("read edge did not fetch next byte");

    property p_capture;
        wr_fall && tx_ready && !tx_pop |=> tx_level == $past(tx_level) + TCW'(1);
    endproperty
    a_capture: assert property (p_capture)
        else $error("write edge did not capture byte");

    property p_room_true;
        !transmit_room_n |-> tx_ready;
    endproperty
    a_room_true: assert property (p_room_true)
        else $error("room shown with transmit FIFO full");

    property p_avail_true;
        !receive_avail_n |-> rx_level != '0;
    endproperty
    a_avail_true: assert property (p_avail_true)
        else $error("data shown with receive FIFO empty");

    property p_float_reset;
        !$past(resetn) |-> !transmit_room_oe && !receive_avail_oe;
    endproperty
    a_float_reset: assert property (p_float_reset)
        else $error("status pins driven in reset");

    property p_power;
        (ctrl[`UFP_CTRL_CONFIGURED] && !ctrl[`UFP_CTRL_SUSPENDED] |=> !configured_awake_n)
        and (ctrl[`UFP_CTRL_SUSPENDED] |=> configured_awake_n);
    endproperty
    a_power: assert property (p_power)
        else $error("power enable wrong");

    property p_wake_input;
        wake_mode |=> !receive_avail_oe ##1 (!wake_mode or !receive_avail_oe);
    endproperty
    a_wake_input: assert property (p_wake_input)
        else $error("receive pin driven while wake enabled");

    property p_resume;
        usb_resume_req |-> $past(wake_cnt) == WCW'(WAKE_CYCLES - 1) && !$past(wk_lvl);
    endproperty
    a_resume: assert property (p_resume)
        else $error("resume without full low period");

    property p_flag_after;
        (rd_fall |=> receive_avail_n) and (wr_fall |=> transmit_room_n);
    endproperty
    a_flag_after: assert property (p_flag_after)
        else $error("flag not raised after transfer");

    c_read:   cover property (rd_fall && rx_valid ##[1:50] rd_rise);
    c_write:  cover property (wr_fall && tx_ready);
    c_full:   cover property (!tx_ready && transmit_room_n);
    c_resume: cover property (usb_resume_req);
endmodule

//--- hdl/ufp_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of
 * the parallel FIFO port.
 * Assumes a 25 MHz core clock and a 12-bit APB byte address.
 */
`ifndef UFP_REGS_SVH
`define UFP_REGS_SVH

// Core clock rate in kHz
`define UFP_CLK_KHZ        25000
// Least time the wake pin must be held low, in ms
`define UFP_WAKE_MIN_MS    20
// Least wake hold time in core clock cycles
`define UFP_WAKE_CYCLES    (`UFP_WAKE_MIN_MS * `UFP_CLK_KHZ)

// APB byte offsets
`define UFP_OFF_CTRL       12'h000
`define UFP_OFF_STATUS     12'h004
`define UFP_OFF_RXDATA     12'h008
`define UFP_OFF_TXDATA     12'h00c
`define UFP_OFF_WAKE       12'h010
`define UFP_OFF_LEVEL      12'h014

// Control register fields
`define UFP_CTRL_CONFIGURED 0
`define UFP_CTRL_SUSPENDED  1
`define UFP_CTRL_WAKE_EN    2
`define UFP_CTRL_RESET      3'h0

// Status register fields
`define UFP_ST_RX_EMPTY    0
`define UFP_ST_RX_FULL     1
`define UFP_ST_TX_EMPTY    2
`define UFP_ST_TX_FULL     3
`define UFP_ST_RD_BUSY     4
`define UFP_ST_WR_BUSY     5

// Transmit data register: valid flag above the byte
`define UFP_TXD_VALID      8

// Wake register: sticky resume flag, write one to clear
`define UFP_WAKE_SEEN      0

// Level register: transmit count starts here
`define UFP_LVL_TX_LSB     16

// Reset levels of the pin synchronisers
`define UFP_SYNC_HIGH      3'h7
`define UFP_SYNC_LOW       3'h0

`endif
